// >>> ipc_input_path_config_regs.sv
// Input path configuration registers with microphone clocks and sample delays
//
// What this block does
// - High-pass filter follows its enable bit
// - Mode field selects differential, single-ended or microphone
// - Rate field sets the microphone clock frequency
// - Path 3 clock runs only in microphone mode
// - Noise cancellation source forces 3.072MHz clock
// - Delay field delays microphone data 0-63 samples
// - Delay unit is the path's own sample
// - Gain 40h-5Fh maps 0-31dB, analogue only
// - Reference field selects logic level supply
// - Path 4 rate field applies in every mode unless its noise cancellation source is selected
`timescale 1ns/1ps
module ipc_input_path_config_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [ipc_pkg::ADDR_W-1:0] regAddr,
    input wire logic [ipc_pkg::DATA_W-1:0] regWdata,
    output logic [ipc_pkg::DATA_W-1:0] regRdata,
    output logic regReadValid,
    input wire logic [1:0] path2SourceMode,
    input wire logic anc3Select,
    input wire logic anc4Select,
    input wire logic mic3DataIn,
    input wire logic mic4DataIn,
    output logic mic3ClockOut,
    output logic mic4ClockOut,
    output ipc_pkg::ipc_path_cfg_s path3Cfg,
    output ipc_pkg::ipc_path_cfg_s path4Cfg,
    output ipc_pkg::ipc_chan_cfg_s chanCfg [ipc_pkg::CHAN_NUM],
    output logic [3:0] delayedMicBit
);
    import ipc_pkg::*;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    function automatic logic [2:0] ctrlIdx(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_P2R_CTRL: return CH_P2R;
            OFS_P3L_CTRL: return CH_P3L;
            OFS_P3R_CTRL: return CH_P3R;
            OFS_P4L_CTRL: return CH_P4L;
            OFS_P4R_CTRL: return CH_P4R;
            default: return CH_NONE;
        endcase
    endfunction : ctrlIdx

    function automatic logic [2:0] dlyIdx(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_P2R_DLY: return CH_P2R;
            OFS_P3L_DLY: return CH_P3L;
            OFS_P3R_DLY: return CH_P3R;
            OFS_P4L_DLY: return CH_P4L;
            OFS_P4R_DLY: return CH_P4R;
            default: return CH_NONE;
        endcase
    endfunction : dlyIdx

    logic [2:0] addrCtrl;
    logic [2:0] addrDly;
    assign addrCtrl = ctrlIdx(regAddr);
    assign addrDly = dlyIdx(regAddr);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [CHAN_NUM-1:0] hpf;
    logic [6:0] gain [CHAN_NUM];
    logic [DLY_W-1:0] dly [CHAN_NUM];
    logic [1:0] osr3;
    logic [1:0] osr4;
    logic [1:0] sup3;
    logic [1:0] sup4;
    logic [1:0] mode3;
    logic [DATA_W-1:0] ctrlWord [CHAN_NUM];
    logic [DATA_W-1:0] dlyWord [CHAN_NUM];

    genvar c;
    generate
        for (c = 0; c < CHAN_NUM; c++) begin : g_chan
            logic ctrlWr;
            logic dlyWr;
            logic analogue;
            assign ctrlWr = regWrite && (addrCtrl == 3'(c));
            assign dlyWr = regWrite && (addrDly == 3'(c));
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    hpf[c] <= 1'b0;
                    gain[c] <= GAIN_RST;
                    dly[c] <= DLY_RST;
                end else begin
                    if (ctrlWr) begin
                        hpf[c] <= regWdata[HPF_BIT];
                        if (c < GAIN_CHANS) begin
                            gain[c] <= regWdata[GAIN_MSB:GAIN_LSB];
                        end
                    end
                    if (dlyWr) begin
                        dly[c] <= regWdata[DLY_MSB:0];
                    end
                end
            end
            // path fields live only in the left control word
            assign ctrlWord[c] = {hpf[c],
                                  (c == CH_P3L) ? osr3 : (c == CH_P4L) ? osr4 : 2'h0,
                                  (c == CH_P3L) ? sup3 : (c == CH_P4L) ? sup4 : 2'h0,
                                  (c == CH_P3L) ? mode3 : 2'h0,
                                  1'b0,
                                  (c < GAIN_CHANS) ? gain[c] : 7'h00,
                                  1'b0};
            assign dlyWord[c] = {{(DATA_W-DLY_W){1'b0}}, dly[c]};
            // gain only counts for an analogue source with a defined code
            assign analogue = (c == CH_P2R) ? (path2SourceMode != MODE_DMIC) :
                              (c < GAIN_CHANS) ? (mode3 != MODE_DMIC) : 1'b0;
            assign chanCfg[c].highpassEn = hpf[c];
            assign chanCfg[c].preampGain = (c < GAIN_CHANS) ? gain[c] : 7'h00;
            assign chanCfg[c].gainActive = (c < GAIN_CHANS) && analogue
                                           && (gain[c] >= GAIN_MIN) && (gain[c] <= GAIN_MAX);
            assign chanCfg[c].sampleDelay = dly[c];
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            osr3 <= RATE_RST;
            osr4 <= RATE_RST;
            sup3 <= REF_MIC_SUPPLY;
            sup4 <= REF_MIC_SUPPLY;
            mode3 <= MODE_RST;
        end else if (regWrite && addrCtrl == CH_P3L) begin
            osr3 <= regWdata[OSR_MSB:OSR_LSB];
            sup3 <= regWdata[SUP_MSB:SUP_LSB];
            mode3 <= regWdata[MODE_MSB:MODE_LSB];
        end else if (regWrite && addrCtrl == CH_P4L) begin
            osr4 <= regWdata[OSR_MSB:OSR_LSB];
            sup4 <= regWdata[SUP_MSB:SUP_LSB];
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    logic [DATA_W-1:0] next_rdata;
    // Unmapped offsets read as zero
    assign next_rdata = (addrCtrl != CH_NONE) ? ctrlWord[addrCtrl] :
                        (addrDly != CH_NONE) ? dlyWord[addrDly] : '0;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            regRdata <= '0;
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= regRead;
            if (regRead) begin
                regRdata <= next_rdata;
            end
        end
    end

    // ****************************************************************
    // Effective path settings
    // ****************************************************************
    // noise cancellation source overrides the rate field
    assign path3Cfg.rate = anc3Select ? RATE_3M072 : osr3;
    // path 4 has no mode, the rate applies unless noise cancellation overrides it
    assign path4Cfg.rate = anc4Select ? RATE_3M072 : osr4;
    assign path3Cfg.levelRef = sup3;
    assign path4Cfg.levelRef = sup4;
    assign path3Cfg.mode = mode3;
    assign path4Cfg.mode = MODE_DMIC;
    // path 3 microphone clock only in microphone mode
    assign path3Cfg.clockRun = (mode3 == MODE_DMIC);
    assign path4Cfg.clockRun = 1'b1;

    // ****************************************************************
    // Microphone clocks and sample delay lines
    // ****************************************************************
    logic [1:0] micData;
    logic [1:0] micClk;
    logic [1:0] riseTick;
    logic [1:0] fallTick;
    logic [HIST_LEN-1:0] hist [4];
    assign micData = {mic4DataIn, mic3DataIn};
    assign mic3ClockOut = micClk[0];
    assign mic4ClockOut = micClk[1];

    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_path
            logic [2:0] sync;
            logic stable;
            localparam int CL = 2 * p;
            localparam int CR = 2 * p + 1;

            ipc_mic_clock_gen u_clk (
                .clock(clock),
                .rst(rst),
                .enable((p == 0) ? path3Cfg.clockRun : path4Cfg.clockRun),
                .rate((p == 0) ? path3Cfg.rate : path4Cfg.rate),
                .micClock(micClk[p]),
                .riseTick(riseTick[p]),
                .fallTick(fallTick[p])
            );

            // Data only counts once the last two stages agree
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    sync <= '0;
                    stable <= 1'b0;
                end else begin
                    sync <= {sync[1:0], micData[p]};
                    if (sync[1] == sync[2]) begin
                        stable <= sync[2];
                    end
                end
            end

            // left shifts on rising edges, right on falling, of this path's clock
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    hist[CL] <= '0;
                    hist[CR] <= '0;
                    delayedMicBit[CL] <= 1'b0;
                    delayedMicBit[CR] <= 1'b0;
                end else begin
                    if (riseTick[p]) begin
                        hist[CL] <= {hist[CL][HIST_LEN-2:0], stable};
                    end
                    if (fallTick[p]) begin
                        hist[CR] <= {hist[CR][HIST_LEN-2:0], stable};
                    end
                    delayedMicBit[CL] <= hist[CL][dly[CL+1]];
                    delayedMicBit[CR] <= hist[CR][dly[CR+1]];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_hpf_write_lands: assert property (
        regWrite && addrCtrl == CH_P3R |=> chanCfg[CH_P3R].highpassEn == $past(regWdata[HPF_BIT]))
        else $error("filter enable did not follow write");
    a_mode_write_lands: assert property (
        regWrite && addrCtrl == CH_P3L |=> path3Cfg.mode == $past(regWdata[MODE_MSB:MODE_LSB]))
        else $error("path 3 mode did not follow write");
    a_rate_write_lands: assert property (
        regWrite && addrCtrl == CH_P4L && !anc4Select ##1 !anc4Select
        |-> path4Cfg.rate == $past(regWdata[OSR_MSB:OSR_LSB]))
        else $error("path 4 rate did not follow write");
    a_clock_off_analogue: assert property (
        mode3 != MODE_DMIC ##1 mode3 != MODE_DMIC |-> !mic3ClockOut && !riseTick[0])
        else $error("path 3 clock runs in analogue mode");
    a_anc_forces_rate: assert property (
        anc3Select |-> path3Cfg.rate == RATE_3M072)
        else $error("noise cancellation rate not forced");
    a_zero_delay_bit: assert property (
        riseTick[1] && dly[CH_P4L] == 6'h00 ##1 $stable(dly[CH_P4L])
        |=> delayedMicBit[2] == $past(g_path[1].stable, 2))
        else $error("zero delay did not pass current sample");
    a_gain_only_valid: assert property (
        chanCfg[CH_P3L].gainActive |-> mode3 != MODE_DMIC
        && chanCfg[CH_P3L].preampGain inside {[GAIN_MIN:GAIN_MAX]})
        else $error("gain active outside analogue range");
    a_ref_write_lands: assert property (
        regWrite && addrCtrl == CH_P3L |=> path3Cfg.levelRef == $past(regWdata[SUP_MSB:SUP_LSB]))
        else $error("level reference did not follow write");
    a_right_keeps_path: assert property (
        regWrite && addrCtrl == CH_P3R |=> $stable(osr3) && $stable(mode3) && $stable(sup3))
        else $error("right control write changed path fields");
    a_read_answers: assert property (
        regRead |=> regReadValid && regRdata == $past(next_rdata))
        else $error("read data wrong");

    c_dmic_path3: cover property (mode3 == MODE_DMIC ##1 riseTick[0]);
    c_anc_override: cover property (anc4Select && osr4 == RATE_768K);
    c_max_delay: cover property (dly[CH_P3L] == 6'h3f ##1 riseTick[0]);

endmodule : ipc_input_path_config_regs

// >>> ipc_mic_clock_gen.sv
// Digital microphone clock generator driven by a phase accumulator
`timescale 1ns/1ps
module ipc_mic_clock_gen (
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    input wire logic [1:0] rate,
    output logic micClock,
    output logic riseTick,
    output logic fallTick
);
    import ipc_pkg::*;

    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] step;
    logic [ACC_W-1:0] next_acc;

    // Rates are not exact divisions of the system clock; the accumulator
    // keeps the average right at the cost of one cycle of edge jitter.
    assign step = (rate == RATE_1M536) ? STEP_1M536 :
                  (rate == RATE_3M072) ? STEP_3M072 :
                  (rate == RATE_6M144) ? STEP_6M144 : STEP_768K;
    assign next_acc = enable ? acc + step : '0;
    assign micClock = acc[ACC_W-1];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc <= '0;
            riseTick <= 1'b0;
            fallTick <= 1'b0;
        end else begin
            acc <= next_acc;
            riseTick <= ~acc[ACC_W-1] & next_acc[ACC_W-1];
            fallTick <= acc[ACC_W-1] & ~next_acc[ACC_W-1];
        end
    end

endmodule : ipc_mic_clock_gen

// >>> ipc_mic_model.sv
// Behavioural digital microphone pair on one clock and data line
`timescale 1ns/1ps
module ipc_mic_model (
    input wire logic micClock,
    input wire logic leftBit,
    input wire logic rightBit,
    output logic micData
);
    realtime lastEdge;
    initial begin
        micData = 1'b0;
        lastEdge = 0;
    end
    // Left slot set up while the clock is low, right slot while it is high
    always @(negedge micClock) begin
        lastEdge = $realtime;
        #5 micData = leftBit;
    end
    always @(posedge micClock) begin
        lastEdge = $realtime;
        #5 micData = rightBit;
    end
    // Released line has no pull, so toggle rather than hold a stale bit
    always #50 if ($realtime - lastEdge > 1000) micData = ~micData;
endmodule : ipc_mic_model

// >>> ipc_pkg.sv
// Constants, field layout and carrier types for the input path configuration registers
package ipc_pkg;

    // ****************************************************************
    // Clock and rates
    // ****************************************************************
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned RATE_1M536_HZ = 1_536_000;
    localparam int unsigned RATE_3M072_HZ = 3_072_000;
    localparam int unsigned RATE_6M144_HZ = 6_144_000;
    localparam int unsigned RATE_768K_HZ = 768_000;
    localparam int ACC_W = 32;

    // Phase step of the microphone clock accumulator for a given rate
    function automatic logic [ACC_W-1:0] ipc_step(input int unsigned hz);
        return ACC_W'((64'(hz) << ACC_W) / 64'(CLK_HZ));
    endfunction : ipc_step

    localparam logic [ACC_W-1:0] STEP_1M536 = ipc_step(RATE_1M536_HZ);
    localparam logic [ACC_W-1:0] STEP_3M072 = ipc_step(RATE_3M072_HZ);
    localparam logic [ACC_W-1:0] STEP_6M144 = ipc_step(RATE_6M144_HZ);
    localparam logic [ACC_W-1:0] STEP_768K = ipc_step(RATE_768K_HZ);

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFS_P2R_CTRL = 12'h31c;
    localparam logic [ADDR_W-1:0] OFS_P2R_DLY = 12'h31e;
    localparam logic [ADDR_W-1:0] OFS_P3L_CTRL = 12'h320;
    localparam logic [ADDR_W-1:0] OFS_P3L_DLY = 12'h322;
    localparam logic [ADDR_W-1:0] OFS_P3R_CTRL = 12'h324;
    localparam logic [ADDR_W-1:0] OFS_P3R_DLY = 12'h326;
    localparam logic [ADDR_W-1:0] OFS_P4L_CTRL = 12'h328;
    localparam logic [ADDR_W-1:0] OFS_P4L_DLY = 12'h32a;
    localparam logic [ADDR_W-1:0] OFS_P4R_CTRL = 12'h32c;
    localparam logic [ADDR_W-1:0] OFS_P4R_DLY = 12'h32e;

    localparam int HPF_BIT = 15;
    localparam int OSR_MSB = 14;
    localparam int OSR_LSB = 13;
    localparam int SUP_MSB = 12;
    localparam int SUP_LSB = 11;
    localparam int MODE_MSB = 10;
    localparam int MODE_LSB = 9;
    localparam int GAIN_MSB = 7;
    localparam int GAIN_LSB = 1;
    localparam int DLY_MSB = 5;
    localparam int DLY_W = 6;
    localparam int HIST_LEN = 64;

    // Channel indices: path2 right, path3 left/right, path4 left/right
    localparam int CHAN_NUM = 5;
    localparam logic [2:0] CH_P2R = 3'h0;
    localparam logic [2:0] CH_P3L = 3'h1;
    localparam logic [2:0] CH_P3R = 3'h2;
    localparam logic [2:0] CH_P4L = 3'h3;
    localparam logic [2:0] CH_P4R = 3'h4;
    localparam logic [2:0] CH_NONE = 3'h7;
    localparam int GAIN_CHANS = 3;

    // ****************************************************************
    // Codes and reset values
    // ****************************************************************
    localparam logic [1:0] RATE_1M536 = 2'h0;
    localparam logic [1:0] RATE_3M072 = 2'h1;
    localparam logic [1:0] RATE_6M144 = 2'h2;
    localparam logic [1:0] RATE_768K = 2'h3;
    localparam logic [1:0] MODE_DIFF = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_DMIC = 2'h2;
    localparam logic [1:0] REF_MIC_SUPPLY = 2'h0;
    localparam logic [6:0] GAIN_MIN = 7'h40;
    localparam logic [6:0] GAIN_MAX = 7'h5f;
    localparam logic [6:0] GAIN_RST = 7'h40;
    localparam logic [1:0] RATE_RST = RATE_3M072;
    localparam logic [1:0] MODE_RST = MODE_DIFF;
    localparam logic [DLY_W-1:0] DLY_RST = 6'h00;

    typedef struct packed {
        logic [1:0] rate;
        logic [1:0] levelRef;
        logic [1:0] mode;
        logic clockRun;
    } ipc_path_cfg_s;

    typedef struct packed {
        logic highpassEn;
        logic [6:0] preampGain;
        logic gainActive;
        logic [DLY_W-1:0] sampleDelay;
    } ipc_chan_cfg_s;

endpackage : ipc_pkg

// >>> tb_ipc_input_path_config_regs.sv
// Self-checking testbench for the input path configuration registers
`timescale 1ns/1ps
module tb_ipc_input_path_config_regs;
    import ipc_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWdata = '0;
    logic [DATA_W-1:0] regRdata;
    logic regReadValid;
    logic [1:0] path2SourceMode = 2'h0;
    logic anc3Select = 1'b0;
    logic anc4Select = 1'b0;
    logic mic3DataIn;
    logic mic4DataIn;
    logic mic3ClockOut;
    logic mic4ClockOut;
    ipc_path_cfg_s path3Cfg;
    ipc_path_cfg_s path4Cfg;
    ipc_chan_cfg_s chanCfg [CHAN_NUM];
    logic [3:0] delayedMicBit;
    logic [1:0] leftBit = 2'h0;
    logic selP4 = 1'b0;
    int n_mismatch = 0;
    int checks_done = 0;
    wire selClk = selP4 ? mic4ClockOut : mic3ClockOut;
    localparam logic [ADDR_W-1:0] OFS [10] = '{OFS_P2R_CTRL, OFS_P2R_DLY, OFS_P3L_CTRL,
        OFS_P3L_DLY, OFS_P3R_CTRL, OFS_P3R_DLY, OFS_P4L_CTRL, OFS_P4L_DLY, OFS_P4R_CTRL,
        OFS_P4R_DLY};
    localparam logic [15:0] RST_VAL [10] = '{16'h0080, 16'h0000, 16'h2080, 16'h0000,
        16'h0080, 16'h0000, 16'h2000, 16'h0000, 16'h0000, 16'h0000};
    localparam logic [15:0] MASK [10] = '{16'h80fe, 16'h003f, 16'hfefe, 16'h003f,
        16'h80fe, 16'h003f, 16'hf800, 16'h003f, 16'h8000, 16'h003f};
    localparam int HZ [4] = '{1536000, 3072000, 6144000, 768000};

    always #5 clock = ~clock;

    ipc_input_path_config_regs ipc_input_path_config_regs_inst (.clock(clock), .rst(rst),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .regReadValid(regReadValid), .path2SourceMode(path2SourceMode),
        .anc3Select(anc3Select), .anc4Select(anc4Select), .mic3DataIn(mic3DataIn),
        .mic4DataIn(mic4DataIn), .mic3ClockOut(mic3ClockOut), .mic4ClockOut(mic4ClockOut),
        .path3Cfg(path3Cfg), .path4Cfg(path4Cfg), .chanCfg(chanCfg),
        .delayedMicBit(delayedMicBit));
    // Right slots stay silent so only the left history carries ones
    ipc_mic_model ipc_mic_model_inst3 (.micClock(mic3ClockOut), .leftBit(leftBit[0]),
        .rightBit(1'b0), .micData(mic3DataIn));
    ipc_mic_model ipc_mic_model_inst4 (.micClock(mic4ClockOut), .leftBit(leftBit[1]),
        .rightBit(1'b0), .micData(mic4DataIn));

    // ****
    // Shared tasks
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(negedge clock);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(negedge clock);
        regWrite = 1'b0;
    endtask : wr

    task automatic rd_expect(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        @(negedge clock);
        regRead = 1'b1;
        regAddr = a;
        @(negedge clock);
        regRead = 1'b0;
        check(regReadValid, 1'b1);
        check(regRdata, exp);
    endtask : rd_expect

    // Counts rising edges of the selected mic clock over a cycle window
    task automatic rises(input int k, input int cycles, output int n, output int t);
        logic prev;
        n = 0;
        t = 0;
        prev = selClk;
        for (int i = 0; i < cycles && n < k; i++) begin
            // Sample off the launching edge so the mic clock has settled
            @(negedge clock);
            if (n > 0) t++;
            if (selClk && !prev) n++;
            prev = selClk;
        end
    endtask : rises

    // ****
    // Scenarios
    // ****
    // reset defaults
    task automatic reset_values();
        for (int i = 0; i < 10; i++) rd_expect(OFS[i], RST_VAL[i]);
        check(path4Cfg.rate, RATE_3M072);
        check(chanCfg[CH_P3R].preampGain, 7'h40);
        check(path4Cfg.mode, MODE_DMIC);
        check(path4Cfg.clockRun, 1'b1);
        check(path3Cfg.clockRun, 1'b0);
    endtask : reset_values

    task automatic access_rw();
        for (int i = 0; i < 10; i++) begin
            wr(OFS[i], 16'hffff);
            rd_expect(OFS[i], MASK[i]);
        end
        for (int c = 0; c < CHAN_NUM; c++) check(chanCfg[c].highpassEn, 1'b1);
        for (int i = 0; i < 10; i++) wr(OFS[i], 16'h5555);
        for (int i = 0; i < 10; i++) rd_expect(OFS[i], 16'h5555 & MASK[i]);
        for (int c = 0; c < CHAN_NUM; c++) check(chanCfg[c].highpassEn, 1'b0);
        wr(12'h330, 16'hffff);
        rd_expect(12'h330, 16'h0000);
        rd_expect(12'h31d, 16'h0000);
        @(negedge clock);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
    endtask : access_rw

    task automatic mode_gain();
        logic [6:0] g [4] = '{7'h3f, 7'h40, 7'h5f, 7'h60};
        for (int m = 0; m < 4; m++) begin
            wr(OFS_P3L_CTRL, 16'(m << 9) | 16'h008a);
            check(path3Cfg.mode, m[1:0]);
            check(path3Cfg.clockRun, m == 2);
            // Reserved mode counts as analogue for the gain
            check(chanCfg[CH_P3L].gainActive, m != 2);
            check(chanCfg[CH_P3R].gainActive, m != 2);
            path2SourceMode = m[1:0];
            @(negedge clock);
            check(chanCfg[CH_P2R].gainActive, m != 2);
            wr(OFS_P3L_CTRL, 16'(m << 11) | 16'h0400);
            check(path3Cfg.levelRef, m[1:0]);
            wr(OFS_P4L_CTRL, 16'(m << 11));
            check(path4Cfg.levelRef, m[1:0]);
        end
        wr(OFS_P3L_CTRL, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_P3R_CTRL, {8'h00, g[i], 1'b0});
            check(chanCfg[CH_P3R].preampGain, g[i]);
            check(chanCfg[CH_P3R].gainActive, i == 1 || i == 2);
        end
    endtask : mode_gain

    // Measures eight mic clock periods against the expected rate
    task automatic measure(input logic p4, input int hz);
        int n;
        int t;
        int exp;
        selP4 = p4;
        exp = 800_000_000 / hz;
        rises(9, 3000, n, t);
        check(n == 9 && t >= exp - 2 && t <= exp + 2, 1'b1);
    endtask : measure

    task automatic clock_rates();
        int n;
        int t;
        // software keeps every path at 8-16kHz while 768kHz is chosen
        for (int r = 0; r < 4; r++) begin
            wr(OFS_P4L_CTRL, 16'(r << 13));
            measure(1'b1, HZ[r]);
            wr(OFS_P3L_CTRL, 16'(r << 13) | 16'h0400);
            measure(1'b0, HZ[r]);
        end
        wr(OFS_P3L_CTRL, 16'h0400);
        wr(OFS_P4L_CTRL, 16'h6000);
        anc3Select = 1'b1;
        anc4Select = 1'b1;
        measure(1'b0, HZ[1]);
        measure(1'b1, HZ[1]);
        check(path4Cfg.rate, RATE_3M072);
        anc3Select = 1'b0;
        anc4Select = 1'b0;
        wr(OFS_P3L_CTRL, 16'h0200);
        selP4 = 1'b0;
        rises(1, 20, n, t);
        rises(1, 400, n, t);
        check(n, 0);
    endtask : clock_rates

    // sample delay counted in the path's own clock periods
    task automatic delay_case(input logic p4, input logic [1:0] rate, input logic [5:0] d);
        int n;
        int t;
        int b;
        int r;
        selP4 = p4;
        b = p4 ? 2 : 0;
        wr(p4 ? OFS_P4L_CTRL : OFS_P3L_CTRL, {1'b0, rate, 2'h0, MODE_DMIC, 9'h0});
        wr(p4 ? OFS_P4L_DLY : OFS_P3L_DLY, {10'h000, d});
        check(chanCfg[b + 1].sampleDelay, d);
        leftBit[p4] = 1'b0;
        rises(70, 12000, n, t);
        check(n, 70);
        // Change the left bit in a high phase so the next rise takes it
        rises(1, 400, r, t);
        leftBit[p4] = 1'b1;
        n = 0;
        for (int i = 0; i < 12000 && delayedMicBit[b] !== 1'b1; i++) begin
            rises(1, 1, r, t);
            n += r;
        end
        check(delayedMicBit[b], 1'b1);
        check(n, 32'(d) + 1);
        check(delayedMicBit[b + 1], 1'b0);
        leftBit[p4] = 1'b0;
    endtask : delay_case

    initial begin
        repeat (5) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        reset_values();
        access_rw();
        reset_values();
        mode_gain();
        clock_rates();
        delay_case(1'b1, RATE_6M144, 6'h00);
        delay_case(1'b1, RATE_6M144, 6'h3f);
        delay_case(1'b0, RATE_768K, 6'h02);
        delay_case(1'b0, RATE_3M072, 6'h05);
        summarize();
    end
endmodule : tb_ipc_input_path_config_regs
